// ### hw/wkup_ctrl.sv
// Wake-up control register block with AXI4-Lite slave
`timescale 1ns/1ps
module wkup_ctrl (
    input  wire logic        aclk,              // Clock, 100 MHz
    input  wire logic        aresetn,           // Power-on reset, active low
    input  wire logic [15:0] s_axi_awaddr,      // Write address
    input  wire logic        s_axi_awvalid,     // Write address valid
    output logic             s_axi_awready,     // Write address ready
    input  wire logic [31:0] s_axi_wdata,       // Write data
    input  wire logic [3:0]  s_axi_wstrb,       // Write strobes
    input  wire logic        s_axi_wvalid,      // Write data valid
    output logic             s_axi_wready,      // Write data ready
    output logic [1:0]       s_axi_bresp,       // Write response
    output logic             s_axi_bvalid,      // Write response valid
    input  wire logic        s_axi_bready,      // Write response ready
    input  wire logic [15:0] s_axi_araddr,      // Read address
    input  wire logic        s_axi_arvalid,     // Read address valid
    output logic             s_axi_arready,     // Read address ready
    output logic [31:0]      s_axi_rdata,       // Read data
    output logic [1:0]       s_axi_rresp,       // Read response
    output logic             s_axi_rvalid,      // Read data valid
    input  wire logic        s_axi_rready,      // Read data ready
    input  wire logic        main_power_good,   // Main power good pin
    input  wire logic        aux_power_present, // Aux power indication pin
    input  wire logic        pcie_reset_pin_n,  // PCIe reset pin, active low
    input  wire logic        in_d3,             // Function is in D3
    input  wire logic        sw_reset,          // Software reset, pulse
    input  wire logic        nvm_pm_wake,       // NVM value of wake enable
    input  wire logic        nvm_pme_on_wake,   // NVM value of PME-on-wake
    input  wire logic        cfg_pme_enable_local_wr,     // Config PME enable written
    input  wire logic        cfg_pme_enable_local_val,    // New config PME enable
    input  wire logic        magic_match,       // Magic packet match level
    output logic             cfg_local_a,    // Config Local_a mirror
    output logic             magic_wake_status_flag, // Magic wake status set
    output logic             wake_pin_n,        // Wake pin, active low
    output logic             pm_pme_msg,        // Send PM_PME message pulse
    output logic             proxy_active,      // Proxying enabled in D3
    output logic             irq                // Level interrupt
);
    import wkup_pkg::*;

    // Pin synchronisers
    logic [1:0] sync_pg, sync_aux, sync_prst, next_sync_pg, next_sync_aux;
    logic [1:0] next_sync_prst;
    logic       prst_q, next_prst_q;
    logic       d3_q, next_d3_q;
    logic       match_q, next_match_q;

    // Register state
    logic       pm_wake_enable, next_pm_wake_enable;
    logic       pme_enable_local, next_pme_enable_local;
    logic       local_a, next_local_a;
    logic       assert_pme_on_pm_wake, next_assert_pme_on_pm_wake;
    logic       port_proxy_enable, next_port_proxy_enable;
    logic       pm_wake_in_d0_enable, next_pm_wake_in_d0_enable;
    logic [1:0] irq_status, next_irq_status, irq_enable, next_irq_enable;

    // Outputs
    logic next_magic_flag, next_wake_pin_n, next_pme_msg, next_proxy;
    logic next_irq, next_cfg_local_a;

    // Bus state
    logic        aw_held, next_aw_held, w_held, next_w_held;
    logic [15:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0]  w_strb, next_w_strb;
    logic        next_awready, next_wready, next_bvalid, next_arready;
    logic        next_rvalid;
    logic [1:0]  next_bresp, next_rresp;
    logic [31:0] next_rdata;

    logic wr_fire, magic_pulse, wake_ok, pme_clr, prst_rise, d3_to_d0;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] o);
        hit = (a[15:2] == o[15:2]);
    endfunction

    always_comb begin
        next_sync_pg   = {sync_pg[0], main_power_good};
        next_sync_aux  = {sync_aux[0], aux_power_present};
        next_sync_prst = {sync_prst[0], pcie_reset_pin_n};
        next_prst_q    = sync_prst[1];
        // Same-clock inputs need only one stage, for edge detection
        next_d3_q      = in_d3;
        next_match_q   = magic_match;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // Start at the idle pin levels so no false edge follows reset
            sync_pg   <= 2'h3;
            sync_aux  <= 2'h3;
            sync_prst <= 2'h3;
            prst_q    <= 1'b1;
            d3_q      <= 1'b0;
            match_q   <= 1'b0;
        end else begin
            sync_pg   <= next_sync_pg;
            sync_aux  <= next_sync_aux;
            sync_prst <= next_sync_prst;
            prst_q    <= next_prst_q;
            d3_q      <= next_d3_q;
            match_q   <= next_match_q;
        end
    end

    // AXI4-Lite write and read channels
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_awready = 1'b0;
        next_wready  = 1'b0;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_arready = 1'b0;
        next_rvalid  = s_axi_rvalid;
        next_rresp   = s_axi_rresp;
        next_rdata   = s_axi_rdata;
        wr_fire      = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        // No new address or data is taken while a response waits
        if (!aw_held && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid) begin
            next_awready = 1'b1;
        end
        if (!w_held && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid) begin
            next_wready = 1'b1;
        end
        // Both halves held: commit the write and answer it
        if (aw_held && w_held && !s_axi_bvalid) begin
            wr_fire      = 1'b1;
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = (hit(aw_addr, WKUP_OFF_CTRL) ||
                            hit(aw_addr, WKUP_OFF_IRQ_EN) ||
                            hit(aw_addr, WKUP_OFF_IRQ_CLR))
                           ? WKUP_RESP_OKAY : WKUP_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
            next_arready = 1'b1;
        end
        // Read data are latched at the address handshake
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = WKUP_RESP_OKAY;
            next_rdata  = 32'h0000_0000;
            if (hit(s_axi_araddr, WKUP_OFF_CTRL)) begin
                next_rdata[WKUP_CTRL_BITS-1:0] = {pm_wake_in_d0_enable,
                    port_proxy_enable, assert_pme_on_pm_wake, local_a,
                    pme_enable_local, pm_wake_enable};
            end else if (hit(s_axi_araddr, WKUP_OFF_IRQ_ST)) begin
                next_rdata[WKUP_IRQ_BITS-1:0] = irq_status;
            end else if (hit(s_axi_araddr, WKUP_OFF_IRQ_EN)) begin
                next_rdata[WKUP_IRQ_BITS-1:0] = irq_enable;
            end else if (!hit(s_axi_araddr, WKUP_OFF_IRQ_CLR)) begin
                next_rresp = WKUP_RESP_SLVERR;
            end
        end
    end

    // Wake control behaviour
    always_comb begin
        logic wr_ctrl, lost_pg;
        wr_ctrl = wr_fire && hit(aw_addr, WKUP_OFF_CTRL) && w_strb[0];
        lost_pg = !sync_pg[1];
        // One packet gives one pulse, however long the match level stands
        magic_pulse = next_match_q && !match_q;
        // Reset pin deasserted: synchronised level rises
        prst_rise   = !prst_q && next_prst_q;
        d3_to_d0    = d3_q && !in_d3;
        // With bit 0 set, wake is honoured in D3, or in any state with bit 5 set
        wake_ok     = pm_wake_enable && (d3_q || pm_wake_in_d0_enable);
        pme_clr     = lost_pg || (!sync_aux[1] && (prst_rise || d3_to_d0));

        next_pm_wake_enable        = pm_wake_enable;
        next_pme_enable_local      = pme_enable_local;
        next_local_a               = local_a;
        next_assert_pme_on_pm_wake = assert_pme_on_pm_wake;
        next_port_proxy_enable     = port_proxy_enable;
        next_pm_wake_in_d0_enable  = pm_wake_in_d0_enable;

        if (wr_ctrl) begin
            next_pm_wake_enable        = w_data[WKUP_BIT_APM_EN];
            next_pme_enable_local      = w_data[WKUP_BIT_PME_ENABLE_LOCAL];
            next_assert_pme_on_pm_wake = w_data[WKUP_BIT_APM_PME];
            next_port_proxy_enable     = w_data[WKUP_BIT_PROXY];
            next_pm_wake_in_d0_enable  = w_data[WKUP_BIT_APM_D0];
            if (w_data[WKUP_BIT_PME_ST]) begin
                next_local_a = 1'b0;
            end
        end
        if (cfg_pme_enable_local_wr) begin
            next_pme_enable_local = cfg_pme_enable_local_val;
        end
        if (prst_rise) begin
            next_pm_wake_enable = nvm_pm_wake;
        end
        if (sw_reset) begin
            next_assert_pme_on_pm_wake = nvm_pme_on_wake;
        end
        // A wake set follows the W1C write, so the set wins
        if (magic_pulse && wake_ok && assert_pme_on_pm_wake) begin
            next_local_a = 1'b1;
        end
        // Power and PCIe reset clears come last and win over a wake
        if (pme_clr) begin
            next_pme_enable_local = 1'b0;
            next_local_a          = 1'b0;
        end

        next_magic_flag     = magic_pulse && wake_ok;
        next_pme_msg        = magic_pulse && wake_ok &&
                              assert_pme_on_pm_wake;
        next_wake_pin_n     = !(next_local_a &&
                              (assert_pme_on_pm_wake || pme_enable_local));
        next_cfg_local_a = next_local_a;
        next_proxy          = port_proxy_enable && d3_q;
    end

    // Interrupt status and enable; a new event wins over a clear
    always_comb begin
        logic wr_en, wr_clr;
        wr_en  = wr_fire && hit(aw_addr, WKUP_OFF_IRQ_EN) && w_strb[0];
        wr_clr = wr_fire && hit(aw_addr, WKUP_OFF_IRQ_CLR) && w_strb[0];
        next_irq_enable = irq_enable;
        next_irq_status = irq_status;

        if (wr_en) begin
            next_irq_enable = w_data[WKUP_IRQ_BITS-1:0];
        end
        if (wr_clr) begin
            next_irq_status = irq_status & ~w_data[WKUP_IRQ_BITS-1:0];
        end
        if (next_magic_flag) begin
            next_irq_status[WKUP_IRQ_MAGIC] = 1'b1;
        end
        if (next_pme_msg) begin
            next_irq_status[WKUP_IRQ_PME] = 1'b1;
        end
        next_irq = |(next_irq_status & next_irq_enable);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= 2'h0;
            irq_enable <= 2'h0;
            irq        <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
            irq        <= next_irq;
        end
    end

    // Bus channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held                <= 1'b0;
            aw_addr                <= 16'h0000;
            w_held                 <= 1'b0;
            w_data                 <= 32'h0000_0000;
            w_strb                 <= 4'h0;
            s_axi_awready          <= 1'b0;
            s_axi_wready           <= 1'b0;
            s_axi_bvalid           <= 1'b0;
            s_axi_bresp            <= WKUP_RESP_OKAY;
            s_axi_arready          <= 1'b0;
            s_axi_rvalid           <= 1'b0;
            s_axi_rresp            <= WKUP_RESP_OKAY;
            s_axi_rdata            <= 32'h0000_0000;
        end else begin
            aw_held                <= next_aw_held;
            aw_addr                <= next_aw_addr;
            w_held                 <= next_w_held;
            w_data                 <= next_w_data;
            w_strb                 <= next_w_strb;
            s_axi_awready          <= next_awready;
            s_axi_wready           <= next_wready;
            s_axi_bvalid           <= next_bvalid;
            s_axi_bresp            <= next_bresp;
            s_axi_arready          <= next_arready;
            s_axi_rvalid           <= next_rvalid;
            s_axi_rresp            <= next_rresp;
            s_axi_rdata            <= next_rdata;
        end
    end

    // Wake register state and outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pm_wake_enable         <= WKUP_CTRL_RESET[WKUP_BIT_APM_EN];
            pme_enable_local       <= WKUP_CTRL_RESET[WKUP_BIT_PME_ENABLE_LOCAL];
            local_a                <= WKUP_CTRL_RESET[WKUP_BIT_PME_ST];
            assert_pme_on_pm_wake  <= WKUP_CTRL_RESET[WKUP_BIT_APM_PME];
            port_proxy_enable      <= WKUP_CTRL_RESET[WKUP_BIT_PROXY];
            pm_wake_in_d0_enable   <= WKUP_CTRL_RESET[WKUP_BIT_APM_D0];
            magic_wake_status_flag <= 1'b0;
            pm_pme_msg             <= 1'b0;
            wake_pin_n             <= 1'b1;
            cfg_local_a         <= 1'b0;
            proxy_active           <= 1'b0;
        end else begin
            pm_wake_enable         <= next_pm_wake_enable;
            pme_enable_local       <= next_pme_enable_local;
            local_a                <= next_local_a;
            assert_pme_on_pm_wake  <= next_assert_pme_on_pm_wake;
            port_proxy_enable      <= next_port_proxy_enable;
            pm_wake_in_d0_enable   <= next_pm_wake_in_d0_enable;
            magic_wake_status_flag <= next_magic_flag;
            pm_pme_msg             <= next_pme_msg;
            wake_pin_n             <= next_wake_pin_n;
            cfg_local_a         <= next_cfg_local_a;
            proxy_active           <= next_proxy;
        end
    end
endmodule

// ### shared/wkup_pkg.sv
// Package with register map, field positions and reset values of wake control
package wkup_pkg;
    localparam logic [15:0] WKUP_OFF_CTRL    = 16'h5800;
    localparam logic [15:0] WKUP_OFF_IRQ_ST  = 16'h5840;
    localparam logic [15:0] WKUP_OFF_IRQ_EN  = 16'h5844;
    localparam logic [15:0] WKUP_OFF_IRQ_CLR = 16'h5848;
    localparam int WKUP_BIT_APM_EN  = 0;
    localparam int WKUP_BIT_PME_ENABLE_LOCAL  = 1;
    localparam int WKUP_BIT_PME_ST  = 2;
    localparam int WKUP_BIT_APM_PME = 3;
    localparam int WKUP_BIT_PROXY   = 4;
    localparam int WKUP_BIT_APM_D0  = 5;
    localparam int WKUP_CTRL_BITS   = 6;
    localparam int WKUP_IRQ_BITS    = 2;
    localparam int WKUP_IRQ_MAGIC   = 0;
    localparam int WKUP_IRQ_PME     = 1;
    localparam logic [5:0] WKUP_CTRL_RESET = 6'h00;
    localparam logic [1:0] WKUP_RESP_OKAY   = 2'h0;
    localparam logic [1:0] WKUP_RESP_SLVERR = 2'h2;
endpackage

// ### tb/wkup_sva.sv
// Port checker for the wake control block
`timescale 1ns/1ps
module wkup_sva (
    input wire logic        aclk,                   // Clock
    input wire logic        aresetn,                // Reset, active low
    input wire logic        s_axi_bvalid,           // Write response valid
    input wire logic        s_axi_bready,           // Write response ready
    input wire logic        s_axi_arvalid,          // Read address valid
    input wire logic        s_axi_arready,          // Read address ready
    input wire logic [31:0] s_axi_rdata,            // Read data
    input wire logic        s_axi_rvalid,           // Read data valid
    input wire logic        s_axi_rready,           // Read data ready
    input wire logic        main_power_good,        // Power good pin
    input wire logic        in_d3,                  // Function in D3
    input wire logic        magic_match,            // Magic match level
    input wire logic        cfg_local_a,         // Config status mirror
    input wire logic        magic_wake_status_flag, // Magic wake pulse
    input wire logic        wake_pin_n,             // Wake pin
    input wire logic        pm_pme_msg,             // Wake message pulse
    input wire logic        proxy_active            // Proxying on
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    bvalid_hold_a:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped before handshake");
    rvalid_hold_a:
        assert property (s_axi_rvalid && !s_axi_rready |=>
            s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed before handshake");
    read_answer_a:
        assert property (s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
        else $error("read answer late");
    flag_pulse_a:
        assert property (magic_wake_status_flag |=> !magic_wake_status_flag)
        else $error("wake flag longer than one cycle");
    flag_cause_a:
        assert property (magic_wake_status_flag |->
            $past(magic_match) && !$past(magic_match, 2))
        else $error("wake flag without magic match");
    msg_pulse_a:
        assert property (pm_pme_msg |-> magic_wake_status_flag ##1 !pm_pme_msg)
        else $error("wake message not tied to one wake");
    power_clear_a:
        assert property (!main_power_good [*5] |-> !cfg_local_a && wake_pin_n)
        else $error("status kept while power bad");
    wake_status_a:
        assert property (!wake_pin_n |-> cfg_local_a)
        else $error("wake pin low without status");
    proxy_off_a:
        assert property (!in_d3 [*3] |-> !proxy_active)
        else $error("proxying outside D3");
endmodule
bind wkup_ctrl wkup_sva chk_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .main_power_good(main_power_good),
    .in_d3(in_d3), .magic_match(magic_match),
    .cfg_local_a(cfg_local_a), .wake_pin_n(wake_pin_n),
    .magic_wake_status_flag(magic_wake_status_flag),
    .pm_pme_msg(pm_pme_msg), .proxy_active(proxy_active));

// ### tb/wkup_host.sv
// Host side model: config PME enable writes and wake message count
`timescale 1ns/1ps
module wkup_host (
    input  wire logic aclk,           // Clock
    input  wire logic cfg_req,        // Bench asks for a config write
    input  wire logic cfg_bit,        // Value to write
    input  wire logic pm_pme_msg,     // Wake message from device
    output logic      cfg_pme_enable_local_wr,  // Config PME enable written
    output logic      cfg_pme_enable_local_val, // New config PME enable
    output int        msg_count       // Wake messages seen
);
    initial begin
        cfg_pme_enable_local_wr = 1'b0;
        cfg_pme_enable_local_val = 1'b1;
        msg_count = 0;
    end
    // Value is only meaningful with the strobe, so it toggles otherwise
    always @(posedge aclk) begin
        cfg_pme_enable_local_wr <= cfg_req;
        cfg_pme_enable_local_val <= cfg_req ? cfg_bit : ~cfg_pme_enable_local_val;
        if (pm_pme_msg === 1'b1)
            msg_count <= msg_count + 1;
    end
endmodule

// ### tb/testbench.sv
// Register level testbench of the wake control block
`timescale 1ns/1ps
module testbench;
    import wkup_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic main_power_good, aux_power_present, pcie_reset_pin_n, in_d3;
    logic sw_reset, nvm_pm_wake, nvm_pme_on_wake, magic_match, cfg_req;
    logic cfg_bit, cfg_pme_enable_local_wr, cfg_pme_enable_local_val, cfg_local_a, irq;
    logic magic_wake_status_flag, wake_pin_n, pm_pme_msg, proxy_active;
    int fails = 0, checks = 0, nflag = 0, msg_count;
    wkup_ctrl dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .main_power_good,
        .aux_power_present, .pcie_reset_pin_n, .in_d3, .sw_reset,
        .nvm_pm_wake, .nvm_pme_on_wake, .cfg_pme_enable_local_wr, .cfg_pme_enable_local_val,
        .magic_match, .cfg_local_a, .magic_wake_status_flag,
        .wake_pin_n, .pm_pme_msg, .proxy_active, .irq);
    wkup_host host_u (.aclk, .cfg_req, .cfg_bit, .pm_pme_msg,
        .cfg_pme_enable_local_wr, .cfg_pme_enable_local_val, .msg_count);
    initial aclk = 1'b0;
    always #5 aclk = ~aclk;
    always @(posedge aclk) if (magic_wake_status_flag === 1'b1) nflag++;
    task automatic tk(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic aw = 1'b0;
        logic w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        // Response is left waiting one cycle before it is accepted
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
        cmp(s_axi_bresp, WKUP_RESP_OKAY);
    endtask
    task automatic rc(input logic [15:0] a, input logic [31:0] d,
                      input logic [1:0] r = WKUP_RESP_OKAY);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        cmp(s_axi_rdata, d);
        cmp(s_axi_rresp, r);
    endtask
    task automatic magic;
        tk(2);
        magic_match <= 1'b1;
        tk(4);
        magic_match <= 1'b0;
        tk(6);
    endtask
    task automatic end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        tk(5000);
        fails++;
        end_sim;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, in_d3, sw_reset} = 4'h0;
        {magic_match, cfg_req, cfg_bit} = 3'h0;
        {main_power_good, aux_power_present, pcie_reset_pin_n} = 3'h7;
        {nvm_pm_wake, nvm_pme_on_wake} = 2'h3;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0;
        s_axi_wstrb = 4'hF;
        tk(5);
        aresetn <= 1'b1;
        tk(1);
        rc(WKUP_OFF_CTRL, 32'h0);
        rc(WKUP_OFF_IRQ_ST, 32'h0);
        rc(16'h5804, 32'h0, WKUP_RESP_SLVERR);
        wr(WKUP_OFF_CTRL, 32'h3F);
        rc(WKUP_OFF_CTRL, 32'h3B);
        cfg_req <= 1'b1;
        tk(1);
        cfg_req <= 1'b0;
        tk(2);
        rc(WKUP_OFF_CTRL, 32'h39);
        $display("register test done");
        wr(WKUP_OFF_CTRL, 32'h01);
        in_d3 <= 1'b1;
        magic;
        cmp(nflag, 1);
        cmp(msg_count, 0);
        cmp(wake_pin_n, 1'b1);
        rc(WKUP_OFF_CTRL, 32'h01);
        rc(WKUP_OFF_IRQ_ST, 32'h1);
        cmp(irq, 1'b0);
        wr(WKUP_OFF_IRQ_EN, 32'h1);
        tk(2);
        cmp(irq, 1'b1);
        wr(WKUP_OFF_IRQ_CLR, 32'h1);
        tk(2);
        cmp(irq, 1'b0);
        $display("status only test done");
        wr(WKUP_OFF_CTRL, 32'h09);
        magic;
        cmp(msg_count, 1);
        rc(WKUP_OFF_IRQ_ST, 32'h3);
        cmp(wake_pin_n, 1'b0);
        cmp(cfg_local_a, 1'b1);
        rc(WKUP_OFF_CTRL, 32'h0D);
        wr(WKUP_OFF_CTRL, 32'h0D);
        tk(2);
        rc(WKUP_OFF_CTRL, 32'h09);
        cmp(cfg_local_a, 1'b0);
        cmp(wake_pin_n, 1'b1);
        in_d3 <= 1'b0;
        magic;
        cmp(msg_count, 1);
        wr(WKUP_OFF_CTRL, 32'h29);
        magic;
        cmp(msg_count, 2);
        $display("wake test done");
        wr(WKUP_OFF_CTRL, 32'h10);
        tk(3);
        cmp(proxy_active, 1'b0);
        in_d3 <= 1'b1;
        tk(3);
        cmp(proxy_active, 1'b1);
        aux_power_present <= 1'b0;
        {nvm_pm_wake, nvm_pme_on_wake} <= 2'h0;
        wr(WKUP_OFF_CTRL, 32'h2B);
        magic;
        rc(WKUP_OFF_CTRL, 32'h2F);
        in_d3 <= 1'b0;
        tk(3);
        rc(WKUP_OFF_CTRL, 32'h29);
        wr(WKUP_OFF_CTRL, 32'h2B);
        pcie_reset_pin_n <= 1'b0;
        tk(4);
        pcie_reset_pin_n <= 1'b1;
        tk(6);
        rc(WKUP_OFF_CTRL, 32'h28);
        sw_reset <= 1'b1;
        tk(1);
        sw_reset <= 1'b0;
        tk(2);
        rc(WKUP_OFF_CTRL, 32'h20);
        aux_power_present <= 1'b1;
        wr(WKUP_OFF_CTRL, 32'h0B);
        in_d3 <= 1'b1;
        magic;
        main_power_good <= 1'b0;
        tk(6);
        cmp(wake_pin_n, 1'b1);
        main_power_good <= 1'b1;
        tk(4);
        rc(WKUP_OFF_CTRL, 32'h09);
        $display("reset source test done");
        end_sim;
    end
endmodule
